// ---- core/intq_pkg.sv ----
// intq_pkg: addresses, field positions, delivery codes and reset values
// for the fixed interrupt queue; shared by the queue core and its tests.
package intq_pkg;
	localparam int          NUM_VEC        = 256;
	localparam int          VEC_W          = 8;
	localparam int          CLASS_W        = 4;
	localparam int          WORD_W         = 32;
	localparam int          CR_W           = 64;
	localparam logic [7:0]  FIRST_USER_VEC = 8'h10; // vectors below are reserved
	localparam logic [4:0]  LEGACY_CLASS_LIMIT = 5'h02; // per-class queue depth
	// memory-mapped register byte addresses
	localparam logic [31:0] ADDR_TASK_PRI  = 32'hfee00080;
	localparam logic [31:0] ADDR_PROC_PRI  = 32'hfee000a0;
	localparam logic [31:0] ADDR_VERSION   = 32'hfee00030;
	localparam logic [31:0] ADDR_EOS       = 32'hfee000b0;
	localparam logic [31:0] ADDR_SPUR      = 32'hfee000f0;
	localparam logic [31:0] ADDR_INSERV    = 32'hfee00100;
	localparam logic [31:0] ADDR_TRIGGER   = 32'hfee00180;
	localparam logic [31:0] ADDR_PENDING   = 32'hfee00200;
	// bank decode: bits 31:7 pick the bank, 6:4 the word, 3:0 must be zero
	localparam int          BANK_LSB       = 7;
	localparam int          WORD_LSB       = 4;
	localparam int          WORD_IDX_W     = 3;
	// spurious vector register fields
	localparam int          SPUR_VEC_MSB   = 7;
	localparam int          SPUR_EN_BIT    = 8;
	localparam int          SPUR_SUPP_BIT  = 12;
	localparam logic [7:0]  SPUR_VEC_RST   = 8'hff;
	// version register fields
	localparam int          VER_SUPP_BIT   = 24;
	localparam int          VER_MAXLVT_LSB = 16;
	localparam logic [7:0]  VER_MAXLVT     = 8'h05;
	// delivery mode codes
	localparam logic [2:0]  DLV_FIXED      = 3'h0;
	localparam logic [2:0]  DLV_LOWEST     = 3'h1;
	localparam logic [2:0]  DLV_SYSMGMT    = 3'h2;
	localparam logic [2:0]  DLV_RSVD       = 3'h3;
	localparam logic [2:0]  DLV_NMI        = 3'h4;
	localparam logic [2:0]  DLV_INIT       = 3'h5;
	localparam logic [2:0]  DLV_STARTUP    = 3'h6;
	localparam logic [2:0]  DLV_EXTCTL     = 3'h7;
	localparam logic [7:0]  TASK_PRI_RST   = 8'h00;
	localparam logic [1:0]  CPL_KERNEL     = 2'h0;
endpackage : intq_pkg

// ---- core/top_bit_finder.sv ----
// top_bit_finder: combinational search for the highest set bit of a vector.
// assumes a single-cycle combinational path is acceptable at the core clock.
`timescale 1ns/1ps
module top_bit_finder #(
	parameter int WIDTH = 256,
	parameter int IDX_W = 8
) (
	input  wire logic [WIDTH-1:0] bits_in,
	output logic                  found_out,
	output logic [IDX_W-1:0]      index_out
);
	// later indices override earlier ones, so the highest index wins
	always_comb begin
		found_out = 1'b0;
		index_out = '0;
		for (int i = 0; i < WIDTH; i++) begin
			if (bits_in[i]) begin
				found_out = 1'b1;
				index_out = i[IDX_W-1:0];
			end
		end
	end
endmodule : top_bit_finder

// ---- core/fixed_intq.sv ----
// fixed_intq: pending/in-service queue, trigger modes, priority threshold
// and end-of-service handling of a local interrupt unit.
// assumes all inputs are synchronous to clk_in and come from core logic.
//
// Behaviour
// RULE1: two read-only 256-bit queues, vectors 0-15 unused
// RULE2: non-fixed deliveries bypass queues to core
// RULE3: accepted fixed interrupt sets its pending bit
// RULE4: core ready moves top pending into service
// RULE5: end-of-service clears top in-service, then redispatch
// RULE6: one pending plus one in-service per vector
// RULE7: legacy mode: two per class, reject more
// RULE8: higher arrival dispatches at once when enabled
// RULE9: trigger bit records edge or level
// RULE10: level vector retirement broadcasts end-of-service
// RULE11: suppress bit 12 blocks broadcast, resets zero
// RULE12: version bit 24 reports suppression support
// RULE13: software writes end-of-service before handler return
// RULE14: task priority clears on reset
// RULE15: threshold blocks classes at or below it
// RULE16: control register maps to task priority 7:4
// RULE17: nonzero privilege access raises protection fault
// RULE18: nonzero reserved control bits raise fault
// RULE19: new priority effective when write completes
// RULE20: unit enabled at power-up; alias needs enable
// RULE21: class is upper four vector bits
// RULE22: processor priority from task and in-service
// RULE23: dispatch only above current threshold
// RULE24: highest bit index wins, one encoder per queue
`timescale 1ns/1ps
module fixed_intq #(
	parameter bit LEGACY_QUEUE  = 1'b0,
	parameter bit SUPP_SUPPORT  = 1'b1,
	parameter logic [7:0] VERSION_ID = 8'h14 // arbitrary value
) (
	input  wire logic                       clk_in,
	input  wire logic                       rst_in,
	input  wire logic                       irq_valid_in,
	input  wire logic [intq_pkg::VEC_W-1:0] irq_vector_in,
	input  wire logic [2:0]                 irq_delivery_in,
	input  wire logic                       irq_level_in,
	input  wire logic                       core_ready_in,
	input  wire logic                       mem_wr_in,
	input  wire logic                       mem_rd_in,
	input  wire logic [31:0]                mem_addr_in,
	input  wire logic [31:0]                mem_wdata_in,
	input  wire logic                       cr_wr_in,
	input  wire logic                       cr_rd_in,
	input  wire logic [intq_pkg::CR_W-1:0]  cr_wdata_in,
	input  wire logic [1:0]                 cpl_in,
	output logic                            irq_reject_out,
	output logic                            direct_valid_out,
	output logic [2:0]                      direct_delivery_out,
	output logic [intq_pkg::VEC_W-1:0]      direct_vector_out,
	output logic                            dispatch_valid_out,
	output logic [intq_pkg::VEC_W-1:0]      dispatch_vector_out,
	output logic                            eos_bcast_out,
	output logic [intq_pkg::VEC_W-1:0]      eos_vector_out,
	output logic [31:0]                     mem_rdata_out,
	output logic [intq_pkg::CR_W-1:0]       cr_rdata_out,
	output logic                            gp_fault_out
);
	import intq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [CLASS_W-1:0] class_of(input logic [VEC_W-1:0] v);
		return v[VEC_W-1 -: CLASS_W]; // RULE21
	endfunction : class_of

	function automatic logic [4:0] count16(input logic [15:0] b);
		logic [4:0] n;
		n = '0;
		for (int i = 0; i < 16; i++) n = n + {4'h0, b[i]};
		return n;
	endfunction : count16

	function automatic logic [WORD_W-1:0] word_of(input logic [NUM_VEC-1:0] v,
		input logic [WORD_IDX_W-1:0] w);
		return v[w*WORD_W +: WORD_W];
	endfunction : word_of

	function automatic logic bank_hit(input logic [31:0] a, input logic [31:0] base);
		return (a[31:BANK_LSB] == base[31:BANK_LSB]) && (a[WORD_LSB-1:0] == 4'h0);
	endfunction : bank_hit

	////////////////////////////////////////////////////////////////////////
	// state
	logic [NUM_VEC-1:0] pend_r;
	logic [NUM_VEC-1:0] inserv_r;
	logic [NUM_VEC-1:0] trig_r;
	logic [7:0]         task_pri_r;
	logic [7:0]         spur_vec_r;
	logic               unit_en_r;
	logic               supp_r;

	////////////////////////////////////////////////////////////////////////
	// top-bit search on both queues, one encoder each
	logic               pend_found;
	logic [VEC_W-1:0]   pend_top;
	logic               serv_found;
	logic [VEC_W-1:0]   serv_top;

	top_bit_finder #(.WIDTH(NUM_VEC), .IDX_W(VEC_W)) u_pend_find ( // RULE24
		.bits_in   (pend_r),
		.found_out (pend_found),
		.index_out (pend_top)
	);
	top_bit_finder #(.WIDTH(NUM_VEC), .IDX_W(VEC_W)) u_serv_find ( // RULE24
		.bits_in   (inserv_r),
		.found_out (serv_found),
		.index_out (serv_top)
	);

	////////////////////////////////////////////////////////////////////////
	// priority: processor priority and dispatch decision
	logic [7:0] proc_pri;
	logic [7:0] serv_vec;
	assign serv_vec = serv_found ? serv_top : 8'h00;
	always_comb begin
		if (task_pri_r[7:4] >= class_of(serv_vec)) begin // RULE22
			proc_pri = task_pri_r;
		end else begin
			proc_pri = {class_of(serv_vec), 4'h0};
		end
	end

	// end-of-service write retires first; no dispatch in that cycle
	logic eos_fire;
	logic disp_fire;
	assign eos_fire  = mem_wr_in && (mem_addr_in == ADDR_EOS);
	// a class at or below the threshold is blocked; preemption falls out
	// because the threshold includes the in-service class
	assign disp_fire = core_ready_in && pend_found && !eos_fire &&
		(class_of(pend_top) > proc_pri[7:4]); // RULE4 RULE8 RULE15 RULE23

	////////////////////////////////////////////////////////////////////////
	// acceptance of incoming requests
	logic is_fixed;
	logic is_direct;
	logic class_full;
	logic acc_fire;
	logic [15:0] cls_pend;
	logic [15:0] cls_serv;
	assign is_fixed  = (irq_delivery_in == DLV_FIXED) || (irq_delivery_in == DLV_LOWEST);
	assign is_direct = !is_fixed && (irq_delivery_in != DLV_RSVD);
	assign cls_pend  = pend_r[{class_of(irq_vector_in), 4'h0} +: 16];
	assign cls_serv  = inserv_r[{class_of(irq_vector_in), 4'h0} +: 16];
	// legacy queue: at most two per class, a repeat merges instead
	assign class_full = LEGACY_QUEUE && !pend_r[irq_vector_in] &&
		((count16(cls_pend) + count16(cls_serv)) >= LEGACY_CLASS_LIMIT); // RULE7
	assign acc_fire  = irq_valid_in && is_fixed && !class_full &&
		(irq_vector_in >= FIRST_USER_VEC); // RULE1

	// reject pulse for a full class
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_reject_out <= 1'b0;
		end else begin
			irq_reject_out <= irq_valid_in && is_fixed && class_full; // RULE7
		end
	end

	// direct deliveries never touch the queues
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			direct_valid_out    <= 1'b0;
			direct_delivery_out <= DLV_FIXED;
			direct_vector_out   <= '0;
		end else begin
			direct_valid_out <= irq_valid_in && is_direct; // RULE2
			if (irq_valid_in && is_direct) begin
				direct_delivery_out <= irq_delivery_in;
				direct_vector_out   <= irq_vector_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pending queue: an arrival wins over the dispatch clear of its bit
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_r <= '0;
		end else begin
			if (disp_fire) begin
				pend_r[pend_top] <= 1'b0; // RULE4
			end
			if (acc_fire) begin
				pend_r[irq_vector_in] <= 1'b1; // RULE3 RULE6
			end
		end
	end

	// in-service queue
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			inserv_r <= '0;
		end else if (eos_fire && serv_found) begin
			inserv_r[serv_top] <= 1'b0; // RULE5
		end else if (disp_fire) begin
			inserv_r[pend_top] <= 1'b1; // RULE4 RULE6
		end
	end

	// trigger mode captured on acceptance
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			trig_r <= '0;
		end else if (acc_fire) begin
			trig_r[irq_vector_in] <= irq_level_in; // RULE9
		end
	end

	// vector handed to the core
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dispatch_valid_out  <= 1'b0;
			dispatch_vector_out <= '0;
		end else begin
			dispatch_valid_out <= disp_fire; // RULE4 RULE5 RULE8
			if (disp_fire) begin
				dispatch_vector_out <= pend_top;
			end
		end
	end

	// end-of-service broadcast for level vectors unless suppressed
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			eos_bcast_out  <= 1'b0;
			eos_vector_out <= '0;
		end else begin
			eos_bcast_out <= eos_fire && serv_found && trig_r[serv_top] && !supp_r; // RULE10 RULE11
			if (eos_fire && serv_found) begin
				eos_vector_out <= serv_top;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register alias: privilege and reserved-bit checks
	logic cr_bad_cpl;
	logic cr_bad_rsvd;
	logic cr_wr_ok;
	logic mmio_task_wr;
	assign cr_bad_cpl  = (cr_wr_in || cr_rd_in) && (cpl_in != CPL_KERNEL); // RULE17
	assign cr_bad_rsvd = cr_wr_in && (cr_wdata_in[CR_W-1:CLASS_W] != '0); // RULE18
	assign cr_wr_ok    = cr_wr_in && !cr_bad_cpl && !cr_bad_rsvd && unit_en_r; // RULE20
	assign mmio_task_wr = mem_wr_in && (mem_addr_in == ADDR_TASK_PRI);

	// task priority, effective from the edge that completes the write
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			task_pri_r <= TASK_PRI_RST; // RULE14
		end else if (cr_wr_ok) begin
			task_pri_r <= {cr_wdata_in[CLASS_W-1:0], 4'h0}; // RULE16 RULE19
		end else if (mmio_task_wr) begin
			task_pri_r <= mem_wdata_in[7:0];
		end
	end

	// fault pulse and alias read data
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gp_fault_out <= 1'b0;
			cr_rdata_out <= '0;
		end else begin
			gp_fault_out <= cr_bad_cpl || cr_bad_rsvd; // RULE17 RULE18
			if (cr_rd_in && !cr_bad_cpl) begin
				cr_rdata_out <= unit_en_r ? {60'h0, task_pri_r[7:4]} : '0; // RULE16 RULE20
			end
		end
	end

	// spurious vector register: enable, suppression, vector
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			spur_vec_r <= SPUR_VEC_RST;
			unit_en_r  <= 1'b1; // RULE20
			supp_r     <= 1'b0; // RULE11
		end else if (mem_wr_in && (mem_addr_in == ADDR_SPUR)) begin
			spur_vec_r <= mem_wdata_in[SPUR_VEC_MSB:0];
			unit_en_r  <= mem_wdata_in[SPUR_EN_BIT];
			supp_r     <= mem_wdata_in[SPUR_SUPP_BIT] && SUPP_SUPPORT; // RULE12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read port, one cycle latency, unmapped reads zero
	logic [WORD_IDX_W-1:0] rd_word;
	logic [31:0]           rd_mux;
	assign rd_word = mem_addr_in[WORD_LSB +: WORD_IDX_W];
	always_comb begin
		rd_mux = 32'h0;
		if (bank_hit(mem_addr_in, ADDR_PENDING)) begin
			rd_mux = word_of(pend_r, rd_word); // RULE1
		end else if (bank_hit(mem_addr_in, ADDR_INSERV)) begin
			rd_mux = word_of(inserv_r, rd_word); // RULE1
		end else if (bank_hit(mem_addr_in, ADDR_TRIGGER)) begin
			rd_mux = word_of(trig_r, rd_word);
		end else if (mem_addr_in == ADDR_TASK_PRI) begin
			rd_mux = {24'h0, task_pri_r};
		end else if (mem_addr_in == ADDR_PROC_PRI) begin
			rd_mux = {24'h0, proc_pri};
		end else if (mem_addr_in == ADDR_SPUR) begin
			rd_mux = 32'h0;
			rd_mux[SPUR_VEC_MSB:0] = spur_vec_r;
			rd_mux[SPUR_EN_BIT]    = unit_en_r;
			rd_mux[SPUR_SUPP_BIT]  = supp_r;
		end else if (mem_addr_in == ADDR_VERSION) begin
			rd_mux = 32'h0;
			rd_mux[7:0]                        = VERSION_ID;
			rd_mux[VER_MAXLVT_LSB +: 8]        = VER_MAXLVT;
			rd_mux[VER_SUPP_BIT]               = SUPP_SUPPORT; // RULE12
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mem_rdata_out <= 32'h0;
		end else if (mem_rd_in) begin
			mem_rdata_out <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_accept_sets;
		acc_fire |=> pend_r[$past(irq_vector_in)];
	endproperty
	a_accept_sets: assert property (p_accept_sets) // RULE3
		else $error("accepted vector not pending");

	property p_reserved_drop;
		irq_valid_in && (irq_vector_in < FIRST_USER_VEC) |=> !pend_r[$past(irq_vector_in)];
	endproperty
	a_reserved_drop: assert property (p_reserved_drop) // RULE1
		else $error("reserved vector queued");

	property p_direct_bypass;
		irq_valid_in && is_direct |=> direct_valid_out &&
			(direct_vector_out == $past(irq_vector_in)) && !irq_reject_out;
	endproperty
	a_direct_bypass: assert property (p_direct_bypass) // RULE2
		else $error("direct delivery lost");

	property p_dispatch_moves;
		disp_fire |=> dispatch_valid_out && inserv_r[dispatch_vector_out];
	endproperty
	a_dispatch_moves: assert property (p_dispatch_moves) // RULE4
		else $error("dispatched vector not in service");

	property p_eos_clears;
		eos_fire && serv_found |=> !inserv_r[$past(serv_top)] && !dispatch_valid_out;
	endproperty
	a_eos_clears: assert property (p_eos_clears) // RULE5
		else $error("end-of-service did not retire top vector");

	property p_trigger_mode;
		acc_fire |=> trig_r[$past(irq_vector_in)] == $past(irq_level_in);
	endproperty
	a_trigger_mode: assert property (p_trigger_mode) // RULE9
		else $error("trigger mode not recorded");

	property p_bcast;
		eos_fire && serv_found && trig_r[serv_top] && !supp_r |=>
			eos_bcast_out && (eos_vector_out == $past(serv_top)) ##1
			(eos_bcast_out == $past(eos_fire && serv_found && trig_r[serv_top] && !supp_r));
	endproperty
	a_bcast: assert property (p_bcast) // RULE10
		else $error("level broadcast missing");

	property p_suppress;
		supp_r && eos_fire |=> !eos_bcast_out;
	endproperty
	a_suppress: assert property (p_suppress) // RULE11
		else $error("broadcast despite suppression");

	property p_threshold;
		disp_fire |-> (class_of(pend_top) > task_pri_r[7:4]) &&
			(!serv_found || (class_of(pend_top) > class_of(serv_top)));
	endproperty
	a_threshold: assert property (p_threshold) // RULE23
		else $error("dispatch at or below threshold");

	property p_cr_write;
		cr_wr_ok |=> task_pri_r == {$past(cr_wdata_in[3:0]), 4'h0};
	endproperty
	a_cr_write: assert property (p_cr_write) // RULE16
		else $error("control write not mapped to task priority");

	property p_cpl_fault;
		cr_bad_cpl |=> gp_fault_out && $stable(task_pri_r);
	endproperty
	a_cpl_fault: assert property (p_cpl_fault) // RULE17
		else $error("privileged access not faulted");

	c_dispatch:  cover property (disp_fire ##1 dispatch_valid_out);
	c_preempt:   cover property (disp_fire && serv_found);
	c_bcast:     cover property (eos_bcast_out);
	c_gp_fault:  cover property (gp_fault_out);
endmodule : fixed_intq

// ---- dv/core_model.sv ----
// core_model: processor-core stand-in on the dispatch side of the queue.
// assumes the bench commands stalls; records every vector it is handed.
`timescale 1ns/1ps
module core_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       stall_in,
	input  wire logic       dispatch_valid_in,
	input  wire logic [7:0] dispatch_vector_in,
	output logic            ready_out,
	output logic [7:0]      last_vec_out,
	output logic [15:0]     taken_cnt_out
);
	////////////////////////////////////////////////////////////////////////////
	// ready and interrupts enabled unless the bench asks for a stall
	assign ready_out = !rst_in && !stall_in;

	// record each dispatched vector and count them
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			last_vec_out  <= 8'h00;
			taken_cnt_out <= 16'h0000;
		end else if (dispatch_valid_in) begin
			last_vec_out  <= dispatch_vector_in;
			taken_cnt_out <= taken_cnt_out + 16'h0001;
		end
	end
endmodule : core_model

// ---- dv/fixed_intq_tb_top.sv ----
// fixed_intq_tb_top: directed scenarios for the fixed interrupt queue.
// assumes core_model stands for the processor core on the dispatch side.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module fixed_intq_tb_top;
	import intq_pkg::*;
	logic        clk_in, rst_in, irq_valid_in, irq_level_in, core_ready_in, stall;
	logic [7:0]  irq_vector_in;
	logic [2:0]  irq_delivery_in, direct_delivery_out;
	logic        mem_wr_in, mem_rd_in, cr_wr_in, cr_rd_in;
	logic [31:0] mem_addr_in, mem_wdata_in, mem_rdata_out, d;
	logic [63:0] cr_wdata_in, cr_rdata_out;
	logic [1:0]  cpl_in;
	logic        irq_reject_out, direct_valid_out, dispatch_valid_out, eos_bcast_out;
	logic        gp_fault_out, lg_reject;
	logic [7:0]  direct_vector_out, dispatch_vector_out, eos_vector_out, last_vec;
	logic [15:0] taken, c0;
	int          err_total, n_checks;

	////////////////////////////////////////////////////////////////////////////
	// clock and design instances
	always #5 clk_in = ~clk_in;
	fixed_intq i_fixed_intq (.clk_in(clk_in), .rst_in(rst_in), .irq_valid_in(irq_valid_in),
		.irq_vector_in(irq_vector_in), .irq_delivery_in(irq_delivery_in),
		.irq_level_in(irq_level_in), .core_ready_in(core_ready_in), .mem_wr_in(mem_wr_in),
		.mem_rd_in(mem_rd_in), .mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in),
		.cr_wr_in(cr_wr_in), .cr_rd_in(cr_rd_in), .cr_wdata_in(cr_wdata_in), .cpl_in(cpl_in),
		.irq_reject_out(irq_reject_out), .direct_valid_out(direct_valid_out),
		.direct_delivery_out(direct_delivery_out), .direct_vector_out(direct_vector_out),
		.dispatch_valid_out(dispatch_valid_out), .dispatch_vector_out(dispatch_vector_out),
		.eos_bcast_out(eos_bcast_out), .eos_vector_out(eos_vector_out),
		.mem_rdata_out(mem_rdata_out), .cr_rdata_out(cr_rdata_out), .gp_fault_out(gp_fault_out));
	core_model i_core_model (.clk_in(clk_in), .rst_in(rst_in), .stall_in(stall),
		.dispatch_valid_in(dispatch_valid_out), .dispatch_vector_in(dispatch_vector_out),
		.ready_out(core_ready_in), .last_vec_out(last_vec), .taken_cnt_out(taken));
	// legacy-queue copy on the same stimulus; only its reject pulse is watched
	fixed_intq #(.LEGACY_QUEUE(1'b1)) i_fixed_intq_legacy (.clk_in(clk_in), .rst_in(rst_in),
		.irq_valid_in(irq_valid_in), .irq_vector_in(irq_vector_in),
		.irq_delivery_in(irq_delivery_in), .irq_level_in(irq_level_in),
		.core_ready_in(core_ready_in), .mem_wr_in(mem_wr_in), .mem_rd_in(mem_rd_in),
		.mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in), .cr_wr_in(cr_wr_in),
		.cr_rd_in(cr_rd_in), .cr_wdata_in(cr_wdata_in), .cpl_in(cpl_in),
		.irq_reject_out(lg_reject), .direct_valid_out(), .direct_delivery_out(),
		.direct_vector_out(), .dispatch_valid_out(), .dispatch_vector_out(),
		.eos_bcast_out(), .eos_vector_out(), .mem_rdata_out(), .cr_rdata_out(),
		.gp_fault_out());

	////////////////////////////////////////////////////////////////////////////
	// bus tasks: drive after an edge, sample one cycle later
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	task automatic mem_rd(input logic [31:0] a);
		@(posedge clk_in); mem_rd_in <= 1'b1; mem_addr_in <= a;
		@(posedge clk_in); mem_rd_in <= 1'b0;
		#1 d = mem_rdata_out;
	endtask : mem_rd
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
		mem_rd(a);
		`CHK(d, e)
	endtask : rd_chk
	task automatic mem_wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_in); mem_wr_in <= 1'b1; mem_addr_in <= a; mem_wdata_in <= v;
		@(posedge clk_in); mem_wr_in <= 1'b0;
		#1;
	endtask : mem_wr
	task automatic irq(input logic [7:0] v, input logic [2:0] m, input logic lvl);
		@(posedge clk_in); irq_valid_in <= 1'b1; irq_vector_in <= v;
		irq_delivery_in <= m; irq_level_in <= lvl;
		@(posedge clk_in); irq_valid_in <= 1'b0;
		#1;
	endtask : irq
	task automatic cr_op(input logic wr, input logic [63:0] v, input logic [1:0] p);
		@(posedge clk_in); cr_wr_in <= wr; cr_rd_in <= !wr; cr_wdata_in <= v; cpl_in <= p;
		@(posedge clk_in); cr_wr_in <= 1'b0; cr_rd_in <= 1'b0; cpl_in <= 2'h0;
		#1;
	endtask : cr_op
	task automatic wait_disp(input logic [7:0] e);
		c0 = taken;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_in); #1;
			if (taken !== c0) begin `CHK(last_vec, e) return; end
		end
		err_total++;
		conclude();
	endtask : wait_disp

	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		for (int i = 0; i < 8; i++) begin
			rd_chk(ADDR_PENDING + 32'(16 * i), 32'h0);
			rd_chk(ADDR_INSERV + 32'(16 * i), 32'h0);
			rd_chk(ADDR_TRIGGER + 32'(16 * i), 32'h0);
		end
		rd_chk(ADDR_TASK_PRI, 32'h0);
		mem_rd(ADDR_SPUR); `CHK(d[12], 1'b0)
		mem_rd(ADDR_VERSION); `CHK(d[24], 1'b1)
	endtask : t_reset
	task automatic t_queue();
		@(posedge clk_in); stall <= 1'b1;
		irq(8'h45, DLV_FIXED, 1'b0); rd_chk(ADDR_PENDING + 32'h20, 32'h20);
		irq(8'h45, DLV_FIXED, 1'b0); irq(8'h45, DLV_FIXED, 1'b0);
		rd_chk(ADDR_PENDING + 32'h20, 32'h20);
		@(posedge clk_in); stall <= 1'b0;
		wait_disp(8'h45);
		rd_chk(ADDR_INSERV + 32'h20, 32'h20);
		rd_chk(ADDR_PENDING + 32'h20, 32'h0);
		irq(8'h45, DLV_FIXED, 1'b0); c0 = taken; repeat (3) @(posedge clk_in);
		rd_chk(ADDR_PENDING + 32'h20, 32'h20);
		`CHK(taken, c0)
		irq(8'h80, DLV_LOWEST, 1'b1); wait_disp(8'h80);
		rd_chk(ADDR_TRIGGER + 32'h40, 32'h1);
		mem_wr(ADDR_EOS, 32'h0);
		`CHK(eos_bcast_out, 1'b1)
		`CHK(eos_vector_out, 8'h80)
		rd_chk(ADDR_INSERV + 32'h40, 32'h0);
		mem_wr(ADDR_EOS, 32'h0); `CHK(eos_bcast_out, 1'b0)
		wait_disp(8'h45);
		mem_wr(ADDR_EOS, 32'h0);
	endtask : t_queue
	task automatic t_direct();
		logic [2:0] m [5] = '{DLV_SYSMGMT, DLV_NMI, DLV_INIT, DLV_STARTUP, DLV_EXTCTL};
		for (int i = 0; i < 5; i++) begin
			irq(8'h30 + 8'(i), m[i], 1'b0);
			`CHK(direct_valid_out, 1'b1)
			`CHK(direct_delivery_out, m[i])
			`CHK(direct_vector_out, 8'h30 + 8'(i))
		end
		rd_chk(ADDR_PENDING + 32'h10, 32'h0);
		irq(8'h0a, DLV_FIXED, 1'b0); irq(8'h40, DLV_RSVD, 1'b0);
		rd_chk(ADDR_PENDING, 32'h0);
		rd_chk(ADDR_PENDING + 32'h20, 32'h0);
	endtask : t_direct
	task automatic t_threshold();
		cr_op(1'b1, 64'h8, 2'h0); `CHK(gp_fault_out, 1'b0)
		rd_chk(ADDR_TASK_PRI, 32'h80);
		cr_op(1'b0, 64'h0, 2'h0); `CHK(cr_rdata_out, 64'h8)
		irq(8'h85, DLV_FIXED, 1'b0); c0 = taken; repeat (3) @(posedge clk_in);
		`CHK(taken, c0)
		irq(8'h95, DLV_FIXED, 1'b0); wait_disp(8'h95);
		rd_chk(ADDR_PROC_PRI, 32'h90);
		mem_wr(ADDR_EOS, 32'h0); rd_chk(ADDR_PROC_PRI, 32'h80);
		cr_op(1'b1, 64'h10, 2'h0); `CHK(gp_fault_out, 1'b1)
		cr_op(1'b1, 64'h0, 2'h1); `CHK(gp_fault_out, 1'b1)
		cr_op(1'b0, 64'h0, 2'h3); `CHK(gp_fault_out, 1'b1)
		rd_chk(ADDR_TASK_PRI, 32'h80);
		cr_op(1'b1, 64'h0, 2'h0); wait_disp(8'h85);
		mem_wr(ADDR_EOS, 32'h0);
	endtask : t_threshold
	task automatic t_suppress();
		mem_wr(ADDR_SPUR, 32'h11ff); rd_chk(ADDR_SPUR, 32'h11ff);
		irq(8'h50, DLV_FIXED, 1'b1); wait_disp(8'h50);
		mem_wr(ADDR_EOS, 32'h0); `CHK(eos_bcast_out, 1'b0)
		mem_wr(ADDR_SPUR, 32'h00ff); cr_op(1'b1, 64'h3, 2'h0);
		rd_chk(ADDR_TASK_PRI, 32'h0);
		mem_wr(ADDR_SPUR, 32'h01ff);
	endtask : t_suppress
	// legacy copy refuses a third vector of one class, merges a repeat
	task automatic t_legacy();
		@(posedge clk_in);
		stall <= 1'b1;
		irq(8'h51, DLV_FIXED, 1'b0);
		irq(8'h52, DLV_FIXED, 1'b0);
		`CHK(lg_reject, 1'b0)
		irq(8'h53, DLV_FIXED, 1'b0);
		`CHK(lg_reject, 1'b1)
		`CHK(irq_reject_out, 1'b0)
		irq(8'h51, DLV_FIXED, 1'b0);
		`CHK(lg_reject, 1'b0)
	endtask : t_legacy

	////////////////////////////////////////////////////////////////////////////
	// main sequence: inputs idle at time zero, reset for four cycles
	initial begin
		clk_in = 1'b0; rst_in = 1'b1; stall = 1'b0; irq_valid_in = 1'b0;
		irq_vector_in = 8'h00; irq_delivery_in = 3'h0; irq_level_in = 1'b0;
		mem_wr_in = 1'b0; mem_rd_in = 1'b0; mem_addr_in = 32'h0; mem_wdata_in = 32'h0;
		cr_wr_in = 1'b0; cr_rd_in = 1'b0; cr_wdata_in = 64'h0; cpl_in = 2'h0;
		err_total = 0; n_checks = 0;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset(); t_queue(); t_direct(); t_threshold(); t_suppress();
		t_legacy();
		conclude();
	end
endmodule : fixed_intq_tb_top
